// file: design/smc_defs.svh
// constants of the serial client: addresses, indices, reset values and timing
//
// Notes on behaviour
// - works with serial clock up to 400 kHz; host keeps it above 10 kHz.
// - with timeout enabled, clock low over 30 ms abandons transaction; off at reset.
// - wrong address or unsupported sequence: no acknowledge, registers untouched.
// - advances only on real clock edges, so long clock stretching is tolerated.
// - write byte: address, index, data, all acknowledged; pointer and data stored.
// - read byte: index, repeated start, read address; one byte returned, host nacks.
// - send byte: index then stop only loads the pointer.
// - receive byte returns register at current pointer; pointer unchanged.
// - alert reply query read: pending alert acknowledges and returns own address.
// - each returned address bit is checked on the bus; losing stops sending.
// - full uncontested address sent: set global alert mask, releasing alert.
// - status untouched; alert reasserts when mask cleared with status still set.
// - standby leaves the serial interface fully working.
// - one-shot write in standby triggers exactly one update of all channels.
// - one-shot write while converting continuously gives no one-shot pulse; the data is still written.
// - bytes are eight bits, msb first; receiver acks low in ninth clock.
// - a stop resets the protocol state, ready for a new start.
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

`define SMC_BYTE_BITS      4'h8
`define SMC_QUERY_ADDR     7'h0C
`define SMC_ONESHOT_IDX    8'h0F
`define SMC_PTR_RST        8'h00
`define SMC_ADDR_RST       7'h00
`define SMC_CLK_HZ         20000000
`define SMC_FSCL_MAX_KHZ   400
`define SMC_FSCL_MIN_KHZ   10
`define SMC_TIMEOUT_MS     30
`define SMC_TIMEOUT_CYCLES (`SMC_TIMEOUT_MS * (`SMC_CLK_HZ / 1000))
`define SMC_SYNC_STAGES    2

`endif

// file: design/smc_pkg.sv
// types shared by the serial client modules
package smc_pkg;

  typedef enum logic [9:0] {
    ST_IDLE      = 10'h001,
    ST_ADDR      = 10'h002,
    ST_ADDR_ACK  = 10'h004,
    ST_INDEX     = 10'h008,
    ST_INDEX_ACK = 10'h010,
    ST_DATA      = 10'h020,
    ST_DATA_ACK  = 10'h040,
    ST_TX        = 10'h080,
    ST_TX_ACK    = 10'h100,
    ST_IGNORE    = 10'h200
  } smc_state_t;

  typedef struct packed {
    logic idx;
    logic dat;
    logic bad;
    logic rw;
    logic qry;
  } smc_flags_t;

  typedef struct packed {
    logic       we;
    logic [7:0] index;
    logic [7:0] data;
  } smc_wr_t;

endpackage : smc_pkg

// file: design/smc_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module smc_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clock_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  input  wire logic [WIDTH-1:0] rst_val_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("smc_sync width must be at least 1");
    end
  endgenerate

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      meta_q <= rst_val_i;
      sync_q <= rst_val_i;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule : smc_sync

// file: design/smc_timeout.sv
// clock-low timeout counter
`timescale 1ns/1ps
module smc_timeout #(
  parameter int CYCLES = 600000
) (
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  input  wire logic run_i,
  output logic      expire_o
);
  localparam int CNT_W = $clog2(CYCLES + 1);
  logic [CNT_W-1:0] cnt_q;

  generate
    if (CYCLES < 1) begin : g_chk
      $error("smc_timeout needs at least one cycle");
    end
  endgenerate

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
    end else if (!run_i) begin
      cnt_q <= '0;
    end else if (cnt_q != CNT_W'(CYCLES - 1)) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  assign expire_o = run_i && (cnt_q == CNT_W'(CYCLES - 1));

endmodule : smc_timeout

// file: design/smc_client.sv
// serial bus client: byte protocols, alert reply query, timeout, one-shot
`timescale 1ns/1ps
`include "smc_defs.svh"
module smc_client
  import smc_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = `SMC_TIMEOUT_CYCLES
) (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  // serial pins
  input  wire logic       serial_clock_line_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic            alert_o,
  output logic            alert_oe_o,
  // configuration
  input  wire logic [6:0] own_addr_i,
  input  wire logic       addr_ready_i,
  input  wire logic       timeout_en_i,
  input  wire logic       standby_i,
  // device register file
  output logic      [7:0] reg_ptr_o,
  input  wire logic [7:0] reg_rdata_i,
  output smc_wr_t         reg_wr_o,
  // alert and conversion control
  input  wire logic       status_any_i,
  input  wire logic       mask_all_i,
  output logic            mask_set_o,
  output logic            one_shot_o,
  output logic            busy_o
);

  generate
    if (TIMEOUT_CYCLES < 1) begin : g_chk
      $error("timeout must be at least one cycle");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling and bus events

  logic [1:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       scl_p_q;
  logic       sda_p_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;

  smc_sync #(
    .WIDTH(2)
  ) u_sync (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .d_i       ({serial_clock_line_i, sda_i}),
    .rst_val_i (2'h3),
    .q_o       (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign scl_rise  = scl_s && !scl_p_q;
  assign scl_fall  = !scl_s && scl_p_q;
  assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_det  = scl_s && scl_p_q && !sda_p_q && sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // own address capture

  logic [6:0] own_addr_q;
  logic       addr_lock_q;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      own_addr_q  <= `SMC_ADDR_RST;
      addr_lock_q <= 1'b0;
    end else if (addr_ready_i && !addr_lock_q) begin
      own_addr_q  <= own_addr_i;
      addr_lock_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alert output

  logic alert_q;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= status_any_i && !mask_all_i;
    end
  end

  assign alert_o    = 1'b0;
  assign alert_oe_o = alert_q;

  ////////////////////////////////////////////////////////////////////////////
  // timeout

  smc_state_t state_q;
  smc_state_t state_d;
  logic       abort;

  smc_timeout #(
    .CYCLES(TIMEOUT_CYCLES)
  ) u_tout (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .run_i     (timeout_en_i && !scl_s && (state_q != ST_IDLE)),
    .expire_o  (abort)
  );

  ////////////////////////////////////////////////////////////////////////////
  // protocol engine

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic       drv_q;
  logic       drv_d;
  smc_flags_t fl_q;
  smc_flags_t fl_d;
  logic [7:0] idx_q;
  logic [7:0] idx_d;
  logic [7:0] dat_q;
  logic [7:0] dat_d;
  logic       ptr_ld;
  logic       wr_go;
  logic       mask_go;
  logic       own_hit;
  logic       qry_hit;

  assign own_hit = addr_lock_q && (sh_q[7:1] == own_addr_q);
  assign qry_hit = (sh_q[7:1] == `SMC_QUERY_ADDR) && sh_q[0] && alert_q;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    drv_d   = drv_q;
    fl_d    = fl_q;
    idx_d   = idx_q;
    dat_d   = dat_q;
    ptr_ld  = 1'b0;
    wr_go   = 1'b0;
    mask_go = 1'b0;
    if (abort) begin
      state_d = ST_IDLE;
      drv_d   = 1'b0;
      fl_d    = '0;
    end else if (start_det) begin
      ptr_ld  = fl_q.idx && !fl_q.dat && !fl_q.bad;
      state_d = ST_ADDR;
      cnt_d   = 4'h0;
      drv_d   = 1'b0;
      fl_d    = '0;
    end else if (stop_det) begin
      ptr_ld  = fl_q.idx && !fl_q.bad;
      wr_go   = fl_q.idx && fl_q.dat && !fl_q.bad;
      state_d = ST_IDLE;
      drv_d   = 1'b0;
      fl_d    = '0;
    end else if (scl_rise) begin
      case (state_q)
        ST_ADDR, ST_INDEX, ST_DATA: begin
          sh_d  = {sh_q[6:0], sda_s};
          cnt_d = cnt_q + 4'h1;
        end
        ST_TX: begin
          cnt_d = cnt_q + 4'h1;
          if (fl_q.qry && !drv_q && !sda_s) begin
            state_d = ST_IGNORE;
            drv_d   = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state_q)
        ST_ADDR: begin
          if (cnt_q == `SMC_BYTE_BITS) begin
            if (own_hit || qry_hit) begin
              state_d = ST_ADDR_ACK;
              drv_d   = 1'b1;
              fl_d.rw = sh_q[0];
              fl_d.qry = qry_hit && !own_hit;
            end else begin
              state_d = ST_IGNORE;
              drv_d   = 1'b0;
            end
          end
        end
        ST_ADDR_ACK: begin
          cnt_d = 4'h0;
          if (fl_q.rw) begin
            state_d = ST_TX;
            sh_d    = fl_q.qry ? {own_addr_q, 1'b0} : reg_rdata_i;
            drv_d   = fl_q.qry ? !own_addr_q[6] : !reg_rdata_i[7];
          end else begin
            state_d = ST_INDEX;
            drv_d   = 1'b0;
          end
        end
        ST_INDEX: begin
          if (cnt_q == `SMC_BYTE_BITS) begin
            state_d  = ST_INDEX_ACK;
            drv_d    = 1'b1;
            idx_d    = sh_q;
            fl_d.idx = 1'b1;
          end
        end
        ST_INDEX_ACK, ST_DATA_ACK: begin
          state_d = ST_DATA;
          cnt_d   = 4'h0;
          drv_d   = 1'b0;
        end
        ST_DATA: begin
          if (cnt_q == `SMC_BYTE_BITS) begin
            if (!fl_q.dat) begin
              state_d  = ST_DATA_ACK;
              drv_d    = 1'b1;
              dat_d    = sh_q;
              fl_d.dat = 1'b1;
            end else begin
              state_d  = ST_IGNORE;
              drv_d    = 1'b0;
              fl_d.bad = 1'b1;
            end
          end
        end
        ST_TX: begin
          if (cnt_q == `SMC_BYTE_BITS) begin
            state_d = ST_TX_ACK;
            drv_d   = 1'b0;
            mask_go = fl_q.qry;
          end else begin
            sh_d  = {sh_q[6:0], 1'b0};
            drv_d = !sh_q[6];
          end
        end
        ST_TX_ACK: begin
          state_d = ST_IGNORE;
          drv_d   = 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      fl_q    <= '0;
      idx_q   <= 8'h00;
      dat_q   <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      fl_q    <= fl_d;
      idx_q   <= idx_d;
      dat_q   <= dat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data line drive

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      drv_q <= 1'b0;
    end else begin
      drv_q <= drv_d;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = drv_q;
  assign busy_o   = (state_q != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // pointer, register write and control pulses

  logic [7:0] ptr_q;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      ptr_q <= `SMC_PTR_RST;
    end else if (ptr_ld) begin
      ptr_q <= idx_q;
    end
  end

  assign reg_ptr_o = ptr_q;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      reg_wr_o <= '0;
    end else begin
      reg_wr_o.we    <= wr_go;
      reg_wr_o.index <= idx_q;
      reg_wr_o.data  <= dat_q;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      mask_set_o <= 1'b0;
      one_shot_o <= 1'b0;
    end else begin
      mask_set_o <= mask_go;
      one_shot_o <= wr_go && (idx_q == `SMC_ONESHOT_IDX) && standby_i;
    end
  end

endmodule : smc_client

// file: tb/smc_client_properties.sv
// port checker of the serial client
`timescale 1ns/1ps
module smc_props
  import smc_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = 200
) (
  // clock and reset
  input wire logic       clock_i,
  input wire logic       reset_n_i,
  // bus and control
  input wire logic       serial_clock_line_i,
  input wire logic       sda_oe_o,
  input wire logic       alert_oe_o,
  input wire logic       timeout_en_i,
  input wire logic       standby_i,
  input wire logic       status_any_i,
  input wire logic       mask_all_i,
  // results
  input wire logic [7:0] reg_ptr_o,
  input wire smc_wr_t    reg_wr_o,
  input wire logic       mask_set_o,
  input wire logic       one_shot_o,
  input wire logic       busy_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  int low_q;
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || serial_clock_line_i || !timeout_en_i) low_q <= 0;
    else if (low_q < TIMEOUT_CYCLES + 8) low_q <= low_q + 1;
  end
  //////////////////////////////////////////////////////////////////////
  sequence s_fell_3ago;
    $past(serial_clock_line_i, 4) && !$past(serial_clock_line_i, 3);
  endsequence
  sequence s_pend2;
    status_any_i && !mask_all_i ##1 status_any_i && !mask_all_i;
  endsequence
  property p_ack_time;
    $rose(sda_oe_o) |-> s_fell_3ago;
  endproperty
  property p_alert_on;
    s_pend2 |-> alert_oe_o;
  endproperty
  property p_alert_off;
    mask_all_i ##1 mask_all_i |-> !alert_oe_o;
  endproperty
  property p_wr;
    reg_wr_o.we |-> reg_ptr_o == reg_wr_o.index ##1 !reg_wr_o.we;
  endproperty
  property p_shot;
    one_shot_o |-> reg_wr_o.we && reg_wr_o.index == 8'h0F && standby_i ##1 !one_shot_o;
  endproperty
  property p_mask;
    mask_set_o |-> alert_oe_o ##1 !mask_set_o;
  endproperty
  property p_idle;
    !busy_o ##1 !busy_o |-> !sda_oe_o;
  endproperty
  property p_ptr;
    $changed(reg_ptr_o) |-> $past(busy_o);
  endproperty
  property p_timeout;
    low_q >= TIMEOUT_CYCLES + 8 |-> !busy_o && !sda_oe_o;
  endproperty
  a_ack_time: assert property (p_ack_time) else $error("drive not 3 clocks after fall");
  a_alert_on: assert property (p_alert_on) else $error("alert missing");
  a_alert_off: assert property (p_alert_off) else $error("alert not masked");
  a_wr: assert property (p_wr) else $error("bad register write");
  a_shot: assert property (p_shot) else $error("bad one-shot");
  a_mask: assert property (p_mask) else $error("bad mask set");
  a_idle: assert property (p_idle) else $error("drive while idle");
  a_ptr: assert property (p_ptr) else $error("pointer moved while idle");
  a_timeout: assert property (p_timeout) else $error("timeout ignored");
endmodule : smc_props

bind smc_client smc_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .serial_clock_line_i(serial_clock_line_i), .sda_oe_o(sda_oe_o),
  .alert_oe_o(alert_oe_o), .timeout_en_i(timeout_en_i), .standby_i(standby_i), .status_any_i(status_any_i),
  .mask_all_i(mask_all_i), .reg_ptr_o(reg_ptr_o), .reg_wr_o(reg_wr_o), .mask_set_o(mask_set_o),
  .one_shot_o(one_shot_o), .busy_o(busy_o)
);

// file: tb/smc_host.sv
// host controller model of the serial bus
`timescale 1ns/1ps
module smc_host (
  // clock
  input  wire logic clock_i,
  // bus
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  int low_n = 6;
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick
  task automatic start();
    scl_o <= 1'b0;
    tick(1);
    sda_oe_o <= 1'b0;
    tick(4);
    scl_o <= 1'b1;
    tick(4);
    sda_oe_o <= 1'b1;
    tick(4);
  endtask : start
  task automatic stop();
    scl_o <= 1'b0;
    tick(1);
    sda_oe_o <= 1'b1;
    tick(4);
    scl_o <= 1'b1;
    tick(4);
    sda_oe_o <= 1'b0;
    tick(4);
  endtask : stop
  task automatic bitx(input logic b, output logic r);
    scl_o <= 1'b0;
    tick(1);
    sda_oe_o <= !b;
    tick(low_n - 1);
    scl_o <= 1'b1;
    tick(1);
    r = sda_i;
    tick(1);
  endtask : bitx
  task automatic xb(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
    bitx(1'b1, ack);
  endtask : xb
endmodule : smc_host

// file: tb/testbench.sv
// self-checking bench of the serial client
`timescale 1ns/1ps
module testbench
  import smc_pkg::*;
;
  localparam logic [6:0] ADR = 7'h4C;
  logic clock_i, reset_n_i, serial_clock_line_i, sda_o, sda_oe_o, alert_o, alert_oe_o, h_oe, a, mask_clr;
  logic addr_ready_i, timeout_en_i, standby_i, status_any_i, mask_all_i, mask_set_o, one_shot_o, busy_o;
  logic [6:0] own_addr_i;
  logic [7:0] reg_ptr_o, reg_rdata_i, d, mem [256];
  logic [2:0] k;
  smc_wr_t reg_wr_o;
  int error_cnt, n_tests, cyc, shots, s;
  wire sda_i = !(sda_oe_o || h_oe);
  smc_client #(
    .TIMEOUT_CYCLES(200)
  ) DUT (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .serial_clock_line_i(serial_clock_line_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .alert_o(alert_o), .alert_oe_o(alert_oe_o), .own_addr_i(own_addr_i),
    .addr_ready_i(addr_ready_i), .timeout_en_i(timeout_en_i), .standby_i(standby_i), .reg_ptr_o(reg_ptr_o),
    .reg_rdata_i(reg_rdata_i), .reg_wr_o(reg_wr_o), .status_any_i(status_any_i), .mask_all_i(mask_all_i),
    .mask_set_o(mask_set_o), .one_shot_o(one_shot_o), .busy_o(busy_o)
  );
  smc_host host (.clock_i(clock_i), .sda_i(sda_i), .scl_o(serial_clock_line_i), .sda_oe_o(h_oe));
  assign reg_rdata_i = mem[reg_ptr_o];
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    shots <= shots + int'(one_shot_o);
    if (!reset_n_i) begin
      for (int i = 0; i < 256; i++) mem[i] <= 8'(i);
    end else if (reg_wr_o.we) begin
      mem[reg_wr_o.index] <= reg_wr_o.data;
    end
    if (!reset_n_i || mask_clr) mask_all_i <= 1'b0;
    else if (mask_set_o) mask_all_i <= 1'b1;
    if (cyc == 60000) begin
      error_cnt++;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [6:0] ad, input logic [7:0] ix, dt, input int n);
    host.start();
    host.xb({ad, 1'b0}, d, k[2]);
    host.xb(ix, d, k[1]);
    k[0] = 1'b0;
    if (n > 2) host.xb(dt, d, k[0]);
    if (n > 3) host.xb(dt, d, k[0]);
    host.stop();
    host.tick(2);
  endtask : wr
  task automatic rd(input logic [6:0] ad, input logic ip, input logic [7:0] ix, tx);
    if (ip) begin
      host.start();
      host.xb({ad, 1'b0}, d, k[2]);
      host.xb(ix, d, k[1]);
    end
    host.start();
    host.xb({ad, 1'b1}, d, a);
    host.xb(tx, d, k[0]);
    host.stop();
  endtask : rd
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  //////////////////////////////////////////////////////////////////////
  initial begin
    reset_n_i = 1'b0;
    own_addr_i = ADR;
    {addr_ready_i, timeout_en_i, standby_i, status_any_i, mask_clr} = 5'h00;
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1'b1;
    host.tick(4);
    chk("ptr", 8'h00, reg_ptr_o);
    chk("open drain", 8'h00, {6'h00, sda_o, alert_o});
    wr(ADR, 8'h25, 8'hA5, 3);
    chk("early", 8'h25, mem[8'h25]);
    addr_ready_i <= 1'b1;
    host.tick(2);
    wr(ADR, 8'h25, 8'hA5, 3);
    chk("wr acks", 8'h00, 8'(k));
    chk("wr data", 8'hA5, mem[8'h25]);
    standby_i <= 1'b1;
    rd(ADR, 1'b1, 8'h25, 8'hFF);
    chk("rd data", 8'hA5, d);
    wr(ADR, 8'h30, 8'h00, 2);
    chk("send ptr", 8'h30, reg_ptr_o);
    chk("send data", 8'h30, mem[8'h30]);
    repeat (2) begin
      rd(ADR, 1'b0, 8'h00, 8'hFF);
      chk("recv", 8'h30, d);
    end
    wr(ADR ^ 7'h01, 8'h31, 8'hEE, 3);
    chk("foreign", 8'h31, mem[8'h31]);
    chk("foreign ptr", 8'h30, reg_ptr_o);
    wr(ADR, 8'h32, 8'h5A, 4);
    chk("extra acks", 8'h01, 8'(k));
    chk("extra data", 8'h32, mem[8'h32]);
    chk("extra ptr", 8'h30, reg_ptr_o);
    s = shots;
    wr(ADR, 8'h0F, 8'h01, 3);
    standby_i <= 1'b0;
    wr(ADR, 8'h0F, 8'h01, 3);
    chk("shots", 8'h01, 8'(shots - s));
    status_any_i <= 1'b1;
    host.tick(3);
    chk("alert", 8'h01, 8'(alert_oe_o));
    rd(7'h0C, 1'b0, 8'h00, 8'hFF);
    chk("reply", {ADR, 1'b0}, d);
    chk("reply ack", 8'h00, 8'(a));
    chk("masked", 8'h10, {3'h0, mask_all_i, 3'h0, alert_oe_o});
    mask_clr <= 1'b1;
    host.tick(1);
    mask_clr <= 1'b0;
    host.tick(2);
    chk("alert back", 8'h01, 8'(alert_oe_o));
    rd(7'h0C, 1'b0, 8'h00, 8'h00);
    chk("lost", 8'h01, {3'h0, mask_all_i, 3'h0, alert_oe_o});
    status_any_i <= 1'b0;
    host.low_n = 300;
    wr(ADR, 8'h40, 8'h77, 3);
    chk("slow", 8'h77, mem[8'h40]);
    timeout_en_i <= 1'b1;
    wr(ADR, 8'h41, 8'h66, 3);
    chk("timeout", 8'h41, mem[8'h41]);
    chk("idle", 8'h00, 8'(busy_o));
    host.low_n = 6;
    wrap_up();
  end
endmodule : testbench
